//--- core/branch_record_state_retention.sv
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module branch_record_state_retention
	import brr_pkg::*;
(
	input  wire logic                ref_clk_in,
	input  wire logic                sys_rst_in,
	// APB slave
	input  wire logic [ADDR_W-1:0]   paddr_in,
	input  wire logic                psel_in,
	input  wire logic                penable_in,
	input  wire logic                pwrite_in,
	input  wire logic [DATA_W-1:0]   pwdata_in,
	input  wire logic [3:0]          pstrb_in,
	output logic      [DATA_W-1:0]   prdata_out,
	output logic                     pready_out,
	output logic                     pslverr_out,
	// Retirement side
	input  wire logic                retire_in,
	input  wire logic                retire_record_in,
	input  wire logic                retire_zero_call_in,
	input  wire branch_entry_s       retire_entry_in,
	input  wire logic                ler_capture_in,
	input  wire branch_entry_s       ler_entry_in,
	input  wire logic                freeze_set_in,
	// Power and reset events
	input  wire logic                idle_enter_in,
	input  wire logic                idle_deep_in,
	input  wire logic                idle_duty_cycle_in,
	input  wire logic                warm_reset_in,
	input  wire logic                core_in_c6_in,
	// Sample record writer
	input  wire logic                sample_req_in,
	output logic                     sample_busy_out,
	output logic                     sample_hdr_valid_out,
	output sample_hdr_s              sample_hdr_out,
	output logic                     sample_entry_valid_out,
	output branch_entry_s            sample_entry_out,
	// Branch trace store
	output logic                     trace_valid_out,
	output branch_entry_s            trace_entry_out,
	output logic                     record_enable_out
);
	// Deep-idle clearing is allowed, not demanded; keep it switchable
	localparam logic CLEAR_ON_DEEP_IDLE = 1'b1;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	branch_entry_s        entries [ENTRY_NUM];
	branch_entry_s        ler;
	logic                 branch_record_enable;
	logic [DEPTH_W-1:0]   record_stack_depth;
	logic [31:0]          sample_data_config;
	logic [31:0]          debug_control_reg;
	logic                 record_freeze_flag;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	logic                 in_entry;
	logic [IDX_W-1:0]     ent_idx;
	logic [1:0]           ent_word;
	logic                 hit;
	logic [31:0]          rd_value;
	logic [31:0]          bytemask;
	logic [31:0]          merged;
	logic [31:0]          clean_word;
	word_kind_e           word_kind;
	logic                 wr_commit;
	logic                 rd_commit;
	logic                 warm_init;
	logic                 deep_clear;
	logic                 do_record;

	assign in_entry = (paddr_in[11:8] == ENTRY_REGION) && (paddr_in[7] == 1'b0)
		&& (paddr_in[3:2] != 2'h3) && (paddr_in[1:0] == 2'h0);
	assign ent_idx  = paddr_in[6:4];
	assign ent_word = paddr_in[3:2];

	always_comb begin
		hit      = 1'b1;
		rd_value = 32'h00000000;
		if (in_entry) begin
			unique case (ent_word)
				WORD_FROM: rd_value = entries[ent_idx].from_addr;
				WORD_TO:   rd_value = entries[ent_idx].to_addr;
				default:   rd_value = entries[ent_idx].info;
			endcase
		end else begin
			unique case (paddr_in)
				OFS_CTRL:     rd_value[CTRL_EN_BIT] = branch_record_enable;
				OFS_DEPTH:    rd_value[DEPTH_W-1:0] = record_stack_depth;
				OFS_SCFG:     rd_value = sample_data_config;
				OFS_DBGCTL:   rd_value = debug_control_reg;
				OFS_PERFCAP:  rd_value[5:0] = FMT_NONE;
				OFS_GSTAT:    rd_value[GSTAT_FRZ_BIT] = record_freeze_flag;
				OFS_LER_FROM: rd_value = ler.from_addr;
				OFS_LER_TO:   rd_value = ler.to_addr;
				OFS_LER_INFO: rd_value = ler.info;
				default:      hit = 1'b0;
			endcase
		end
	end

	// Byte lanes merged against current contents so partial writes keep the rest
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			bytemask[b*8 +: 8] = {8{pstrb_in[b]}};
		end
		merged = (rd_value & ~bytemask) | (pwdata_in & bytemask);
	end

	// Info words get the undefined-bit mask, address words the sign extension
	always_comb begin
		word_kind = KIND_ADDR;
		if ((in_entry && ent_word == WORD_INFO) || (!in_entry && paddr_in == OFS_LER_INFO)) begin
			word_kind = KIND_INFO;
		end
	end

	record_canon u_canon (
		.raw_in    (merged),
		.kind_in   (word_kind),
		.clean_out (clean_word)
	);

	// Commit only at the edge where the master sees pready high
	assign wr_commit  = psel_in && penable_in && pready_out && pwrite_in && hit;
	assign rd_commit  = psel_in && penable_in && !pready_out;
	assign warm_init  = warm_reset_in && core_in_c6_in;
	assign deep_clear = CLEAR_ON_DEEP_IDLE && idle_enter_in && idle_deep_in
		&& !idle_duty_cycle_in;
	assign do_record  = retire_in && retire_record_in && branch_record_enable
		&& !record_freeze_flag && !retire_zero_call_in;

	// ----------------------------------------------------------------
	// APB answer
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out  <= 32'h00000000;
		end else begin
			pready_out  <= rd_commit;
			pslverr_out <= rd_commit && !hit;
			if (rd_commit && !pwrite_in) begin
				prdata_out <= hit ? rd_value : 32'h00000000;
			end
		end
	end

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in || warm_init) begin
			branch_record_enable <= 1'b0;
		end else if (warm_reset_in) begin
			branch_record_enable <= 1'b0;
		end else if (wr_commit && !in_entry && paddr_in == OFS_CTRL) begin
			branch_record_enable <= merged[CTRL_EN_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Depth, sample config, debug control
	// ----------------------------------------------------------------
	// Warm reset without C6 falls through: these hold their values
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in || warm_init) begin
			record_stack_depth <= DEPTH_RESET;
			sample_data_config <= 32'h00000000;
			debug_control_reg  <= 32'h00000000;
		end else if (wr_commit && !in_entry) begin
			unique case (paddr_in)
				OFS_DEPTH: begin
					record_stack_depth <= (merged[DEPTH_W-1:0] > DEPTH_MAX)
						? DEPTH_MAX : merged[DEPTH_W-1:0];
				end
				OFS_SCFG:   sample_data_config <= merged & SCFG_MASK;
				OFS_DBGCTL: debug_control_reg  <= merged & DBG_KEEP_MASK;
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Freeze flag
	// ----------------------------------------------------------------
	// Hardware set wins over a software write-one-to-clear in the same cycle
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in || warm_init) begin
			record_freeze_flag <= 1'b0;
		end else if (freeze_set_in) begin
			record_freeze_flag <= 1'b1;
		end else if (wr_commit && !in_entry && paddr_in == OFS_GSTAT
				&& merged[GSTAT_FRZ_BIT]) begin
			record_freeze_flag <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Last-exception record
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in || warm_init) begin
			ler <= '0;
		end else if (ler_capture_in && branch_record_enable && !record_freeze_flag) begin
			ler <= ler_entry_in;
		end else if (wr_commit && !in_entry) begin
			unique case (paddr_in)
				OFS_LER_FROM: ler.from_addr <= clean_word;
				OFS_LER_TO:   ler.to_addr   <= clean_word;
				OFS_LER_INFO: ler.info      <= clean_word;
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Entry stack, index 0 newest
	// ----------------------------------------------------------------
	generate
		for (genvar i = 0; i < ENTRY_NUM; i++) begin : g_entry
			always_ff @(posedge ref_clk_in) begin
				if (sys_rst_in || warm_init) begin
					entries[i] <= '0;
				end else if (deep_clear) begin
					entries[i] <= '0;
				end else if (do_record) begin
					if (i == 0) begin
						entries[i] <= retire_entry_in;
					end else begin
						entries[i] <= entries[(i == 0) ? 0 : i - 1];
					end
				end else if (wr_commit && in_entry && ent_idx == IDX_W'(i)) begin
					unique case (ent_word)
						WORD_FROM: entries[i].from_addr <= clean_word;
						WORD_TO:   entries[i].to_addr   <= clean_word;
						default:   entries[i].info      <= clean_word;
					endcase
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Branch trace store
	// ----------------------------------------------------------------
	// With recording off the old entry 0 goes out again, a tolerated repeat
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			trace_valid_out <= 1'b0;
			trace_entry_out <= '0;
		end else begin
			trace_valid_out <= retire_in && !record_freeze_flag
				&& !retire_zero_call_in;
			if (retire_in) begin
				trace_entry_out <= do_record ? retire_entry_in : entries[0];
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			record_enable_out <= 1'b0;
		end else begin
			record_enable_out <= branch_record_enable && !record_freeze_flag;
		end
	end

	// ----------------------------------------------------------------
	// Sample record export
	// ----------------------------------------------------------------
	logic             smp_strobe;
	logic [IDX_W-1:0] smp_idx;

	sample_export u_sample (
		.ref_clk_in    (ref_clk_in),
		.sys_rst_in    (sys_rst_in),
		.req_in        (sample_req_in),
		.include_in    (sample_data_config[SCFG_INCL_BIT]),
		.cfg_count_in  (sample_data_config[SCFG_CNT_LSB +: CNT_W]),
		.depth_in      (record_stack_depth),
		.hdr_valid_out (sample_hdr_valid_out),
		.hdr_out       (sample_hdr_out),
		.rd_strobe_out (smp_strobe),
		.rd_idx_out    (smp_idx),
		.busy_out      (sample_busy_out)
	);

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			sample_entry_valid_out <= 1'b0;
			sample_entry_out       <= '0;
		end else begin
			sample_entry_valid_out <= smp_strobe;
			if (smp_strobe) begin
				sample_entry_out <= entries[smp_idx];
			end
		end
	end

endmodule : branch_record_state_retention
`default_nettype wire

//--- core/brr_pkg.sv
package brr_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int              DATA_W       = 32;
	localparam int              ADDR_W       = 12;
	localparam int              ENTRY_NUM    = 8;
	localparam int              IDX_W        = 3;
	localparam int              DEPTH_W      = 4;
	localparam int              CNT_W        = 5;
	localparam int              LINADDR_MSB  = 23;
	localparam logic [3:0]      DEPTH_RESET  = 4'h8;
	localparam logic [3:0]      DEPTH_MAX    = 4'h8;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [11:0]     OFS_CTRL     = 12'h000;
	localparam logic [11:0]     OFS_DEPTH    = 12'h004;
	localparam logic [11:0]     OFS_SCFG     = 12'h008;
	localparam logic [11:0]     OFS_DBGCTL   = 12'h00C;
	localparam logic [11:0]     OFS_PERFCAP  = 12'h010;
	localparam logic [11:0]     OFS_GSTAT    = 12'h014;
	localparam logic [11:0]     OFS_LER_FROM = 12'h018;
	localparam logic [11:0]     OFS_LER_TO   = 12'h01C;
	localparam logic [11:0]     OFS_LER_INFO = 12'h020;
	localparam logic [3:0]      ENTRY_REGION = 4'h1;
	localparam logic [1:0]      WORD_FROM    = 2'h0;
	localparam logic [1:0]      WORD_TO      = 2'h1;
	localparam logic [1:0]      WORD_INFO    = 2'h2;

	// ----------------------------------------------------------------
	// Field positions and fixed values
	// ----------------------------------------------------------------
	localparam int              CTRL_EN_BIT   = 0;
	localparam int              SCFG_INCL_BIT = 3;
	localparam int              SCFG_CNT_LSB  = 24;
	localparam int              DBG_LEGACY_BIT = 0;
	localparam logic [31:0]     DBG_KEEP_MASK = 32'h0000FFFE;
	localparam logic [31:0]     SCFG_MASK     = 32'h1F000008;
	localparam logic [5:0]      FMT_NONE      = 6'h3F;
	localparam int              GSTAT_FRZ_BIT = 0;
	localparam logic [31:0]     INFO_DEF_MASK = 32'h8001FFFF;
	localparam logic [15:0]     SAMPLE_BASE_BYTES  = 16'h0020;
	localparam logic [15:0]     SAMPLE_ENTRY_BYTES = 16'h000C;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [31:0] from_addr;
		logic [31:0] to_addr;
		logic [31:0] info;
	} branch_entry_s;

	typedef struct packed {
		logic [CNT_W-1:0] count;
		logic [15:0]      size;
		logic [31:0]      format;
	} sample_hdr_s;

	typedef enum logic [1:0] {
		KIND_ADDR = 2'b01,
		KIND_INFO = 2'b10
	} word_kind_e;

	typedef enum logic [2:0] {
		SMP_IDLE = 3'b001,
		SMP_HDR  = 3'b010,
		SMP_DATA = 3'b100
	} sample_state_e;

endpackage : brr_pkg

//--- core/record_canon.sv
`timescale 1ns/1ps
`default_nettype none
module record_canon
	import brr_pkg::*;
(
	input  wire logic [31:0] raw_in,
	input  wire word_kind_e  kind_in,
	output logic      [31:0] clean_out
);
	always_comb begin
		unique case (kind_in)
			KIND_ADDR: clean_out = {{(31-LINADDR_MSB){raw_in[LINADDR_MSB]}},
				raw_in[LINADDR_MSB:0]};
			KIND_INFO: clean_out = raw_in & INFO_DEF_MASK;
			// Illegal kind codes keep the safe masked value, no latch
			default:   clean_out = raw_in & INFO_DEF_MASK;
		endcase
	end
endmodule : record_canon
`default_nettype wire

//--- core/sample_export.sv
`timescale 1ns/1ps
`default_nettype none
module sample_export
	import brr_pkg::*;
(
	input  wire logic               ref_clk_in,
	input  wire logic               sys_rst_in,
	input  wire logic               req_in,
	input  wire logic               include_in,
	input  wire logic [CNT_W-1:0]   cfg_count_in,
	input  wire logic [DEPTH_W-1:0] depth_in,
	output logic                    hdr_valid_out,
	output sample_hdr_s             hdr_out,
	output logic                    rd_strobe_out,
	output logic [IDX_W-1:0]        rd_idx_out,
	output logic                    busy_out
);
	sample_state_e    state;
	logic [CNT_W-1:0] eff_count;
	logic [CNT_W-1:0] left;

	// Clamp requested count to the live stack depth
	always_comb begin
		eff_count = 5'(depth_in) < cfg_count_in ? 5'(depth_in) : cfg_count_in;
		if (!include_in) begin
			eff_count = 5'h00;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			state         <= SMP_IDLE;
			left          <= 5'h00;
			hdr_valid_out <= 1'b0;
			hdr_out       <= '0;
			rd_strobe_out <= 1'b0;
			rd_idx_out    <= '0;
			busy_out      <= 1'b0;
		end else begin
			hdr_valid_out <= 1'b0;
			rd_strobe_out <= 1'b0;
			unique case (state)
				SMP_IDLE: begin
					if (req_in) begin
						left     <= eff_count;
						busy_out <= 1'b1;
						state    <= SMP_HDR;
					end
				end
				SMP_HDR: begin
					hdr_valid_out  <= 1'b1;
					hdr_out.count  <= left;
					hdr_out.size   <= SAMPLE_BASE_BYTES
						+ 16'(16'(left) * SAMPLE_ENTRY_BYTES);
					hdr_out.format <= '0;
					hdr_out.format[SCFG_INCL_BIT] <= include_in;
					hdr_out.format[SCFG_CNT_LSB +: CNT_W] <= left;
					rd_idx_out     <= '0;
					if (left == 5'h00) begin
						busy_out <= 1'b0;
						state    <= SMP_IDLE;
					end else begin
						state <= SMP_DATA;
					end
				end
				SMP_DATA: begin
					rd_strobe_out <= 1'b1;
					rd_idx_out    <= IDX_W'(hdr_out.count - left);
					left          <= left - 5'h01;
					if (left == 5'h01) begin
						busy_out <= 1'b0;
						state    <= SMP_IDLE;
					end
				end
			endcase
		end
	end
endmodule : sample_export
`default_nettype wire

//--- tb/brr_props.sv
`timescale 1ns/1ps
`default_nettype none
module brr_props
	import brr_pkg::*;
(
	input wire logic              ref_clk_in,
	input wire logic              sys_rst_in,
	input wire logic [ADDR_W-1:0] paddr_in,
	input wire logic              psel_in,
	input wire logic              penable_in,
	input wire logic              pready_out,
	input wire logic              pslverr_out,
	input wire logic              retire_in,
	input wire logic              retire_zero_call_in,
	input wire logic              warm_reset_in,
	input wire logic              sample_req_in,
	input wire logic              sample_busy_out,
	input wire logic              sample_hdr_valid_out,
	input wire sample_hdr_s       sample_hdr_out,
	input wire logic              sample_entry_valid_out,
	input wire logic              trace_valid_out,
	input wire logic              record_enable_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);
	// ----------------------------------------------------------------
	// Entry counter per sample record
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] hdr_n;
	logic [CNT_W-1:0] ent_n;
	wire              acc = psel_in && penable_in && !pready_out;
	wire              ent_ok = (paddr_in[11:8] == ENTRY_REGION && paddr_in[3:2] != 2'h3
		&& !paddr_in[7] && paddr_in[1:0] == 2'h0)
		|| paddr_in inside {OFS_LER_FROM, OFS_LER_TO, OFS_LER_INFO};
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			hdr_n <= '0;
			ent_n <= '0;
		end else if (sample_hdr_valid_out) begin
			hdr_n <= sample_hdr_out.count;
			ent_n <= '0;
		end else if (sample_entry_valid_out) begin
			ent_n <= ent_n + 5'h01;
		end
	end
	a_ready_pulse: assert property (acc |=> pready_out ##1 !pready_out)
		else $error("pready not one pulse");
	a_err_with_ready: assert property (pslverr_out |-> pready_out)
		else $error("pslverr without pready");
	a_entry_no_fault: assert property (acc && ent_ok |=> !pslverr_out)
		else $error("record write faulted");
	a_zero_call_mute: assert property (retire_in && retire_zero_call_in |=> !trace_valid_out)
		else $error("zero call traced");
	a_trace_cause: assert property (trace_valid_out |-> $past(retire_in))
		else $error("trace without retirement");
	a_sample_start: assert property (sample_req_in && !sample_busy_out
		|=> sample_busy_out ##1 sample_hdr_valid_out)
		else $error("sample header late");
	a_size_match: assert property (sample_hdr_valid_out |-> sample_hdr_out.size ==
		SAMPLE_BASE_BYTES + SAMPLE_ENTRY_BYTES * 16'(sample_hdr_out.count))
		else $error("sample size wrong");
	a_fmt_count: assert property (sample_hdr_valid_out |->
		sample_hdr_out.format[28:24] == sample_hdr_out.count
		&& sample_hdr_out.count <= {1'b0, DEPTH_MAX})
		else $error("format count wrong");
	a_fmt_include: assert property (sample_hdr_valid_out && sample_hdr_out.count != 5'h00
		|-> sample_hdr_out.format[SCFG_INCL_BIT])
		else $error("include bit missing");
	a_entry_bound: assert property (sample_entry_valid_out |-> ent_n < hdr_n)
		else $error("too many sample entries");
	a_warm_disable: assert property (warm_reset_in && !psel_in |-> ##2 !record_enable_out)
		else $error("warm reset kept recording");
endmodule : brr_props
bind branch_record_state_retention brr_props u_props (.*);
`default_nettype wire

//--- tb/retire_model.sv
`timescale 1ns/1ps
`default_nettype none
module retire_model
	import brr_pkg::*;
(
	input  wire logic    ref_clk_in,
	input  wire logic    hdr_valid_in,
	input  wire sample_hdr_s hdr_in,
	input  wire logic    entry_valid_in,
	output logic         retire_out,
	output logic         record_out,
	output logic         zero_call_out,
	output branch_entry_s entry_out,
	output logic         ler_out,
	output logic         freeze_out,
	output logic         req_out,
	output sample_hdr_s  hdr_seen_out,
	output logic [4:0]   entry_count_out
);
	initial begin
		{req_out, freeze_out, ler_out, retire_out} = 4'h0;
		{record_out, zero_call_out} = 2'h0;
		entry_out = '0;
		hdr_seen_out = '0;
		entry_count_out = 5'h00;
	end
	// ----------------------------------------------------------------
	// One-cycle strobe: sel is {req, freeze, ler, retire}
	// ----------------------------------------------------------------
	task automatic drive(input logic [3:0] sel, input logic rec, input logic zc,
		input branch_entry_s e);
		@(posedge ref_clk_in);
		{req_out, freeze_out, ler_out, retire_out} <= sel;
		record_out <= rec;
		zero_call_out <= zc;
		entry_out <= e;
		@(posedge ref_clk_in);
		{req_out, freeze_out, ler_out, retire_out} <= 4'h0;
		// Stale data would hide a late capture
		entry_out <= ~e;
	endtask : drive
	always @(posedge ref_clk_in) begin
		if (hdr_valid_in) begin
			hdr_seen_out <= hdr_in;
			entry_count_out <= 5'h00;
		end else if (entry_valid_in) begin
			entry_count_out <= entry_count_out + 5'h01;
		end
	end
endmodule : retire_model
`default_nettype wire

//--- tb/test_branch_record_state_retention.sv
`timescale 1ns/1ps
`default_nettype none
module test_branch_record_state_retention
	import brr_pkg::*;
;
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic [11:0]       paddr = 12'h000;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [31:0]       pwdata = 32'h00000000;
	logic [31:0]       prdata, rd;
	logic              pready, pslverr, err;
	logic              ret, rec, zc, ler, frz, req, busy, hdr_v, ent_v, trc_v, rec_en;
	logic [4:0]        pwr_v = 5'h00;
	branch_entry_s     ent, smp_ent, trc_ent;
	sample_hdr_s       hdr, hdr_seen;
	logic [4:0]        n_ent;
	int                n_mismatch = 0, comparisons = 0, cycles = 0;
	branch_entry_s     e1 = '{32'h00001000, 32'h00002000, 32'h80000005};
	branch_entry_s     e2 = '{32'h00003000, 32'h00004000, 32'h00000002};
	always #50 clk = ~clk;
	branch_record_state_retention uut (.ref_clk_in(clk), .sys_rst_in(rst),
		.paddr_in(paddr), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.pwdata_in(pwdata), .pstrb_in(4'hF), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .retire_in(ret), .retire_record_in(rec),
		.retire_zero_call_in(zc), .retire_entry_in(ent), .ler_capture_in(ler),
		.ler_entry_in(ent), .freeze_set_in(frz), .idle_enter_in(pwr_v[4]),
		.idle_deep_in(pwr_v[3]), .idle_duty_cycle_in(pwr_v[2]),
		.warm_reset_in(pwr_v[1]), .core_in_c6_in(pwr_v[0]), .sample_req_in(req),
		.sample_busy_out(busy), .sample_hdr_valid_out(hdr_v), .sample_hdr_out(hdr),
		.sample_entry_valid_out(ent_v), .sample_entry_out(smp_ent),
		.trace_valid_out(trc_v), .trace_entry_out(trc_ent), .record_enable_out(rec_en));
	retire_model p (.ref_clk_in(clk), .hdr_valid_in(hdr_v), .hdr_in(hdr),
		.entry_valid_in(ent_v), .retire_out(ret), .record_out(rec), .zero_call_out(zc),
		.entry_out(ent), .ler_out(ler), .freeze_out(frz), .req_out(req),
		.hdr_seen_out(hdr_seen), .entry_count_out(n_ent));
	branch_entry_s     first_ent;
	// Keeps the first exported entry of each sample record
	always @(posedge clk) begin
		if (ent_v && n_ent == 5'h00) begin
			first_ent <= smp_ent;
		end
	end
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : give_verdict
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	task automatic chk(input logic [95:0] got, input logic [95:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// pready ends this wait; without pready only the bench timeout ends it
		do begin
			@(posedge clk);
		end while (!pready);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h00000000);
		chk(rd, exp);
	endtask : rdc
	task automatic pwr(input logic [4:0] v);
		@(posedge clk);
		pwr_v <= v;
		@(posedge clk);
		pwr_v <= 5'h00;
	endtask : pwr
	task automatic smp(input logic [4:0] n, input logic [31:0] fmt);
		int k = 0;
		p.drive(4'h8, 1'b0, 1'b0, e1);
		do begin
			@(posedge clk);
			k++;
		end while (busy && k < 40);
		repeat (3) @(posedge clk);
		#1;
		chk(hdr_seen.count, n);
		chk(hdr_seen.size, 16'h0020 + 16'h000C * n);
		chk(hdr_seen.format, fmt);
		chk(n_ent, n);
	endtask : smp
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		rdc(OFS_PERFCAP, 32'h0000003F);
		rdc(OFS_DEPTH, 32'h00000008);
		wr(OFS_DBGCTL, 32'hFFFFFFFF);
		rdc(OFS_DBGCTL, 32'h0000FFFE);
		apb(1'b0, 12'h180, 32'h00000000);
		chk(err, 1'b1);
		wr(OFS_PERFCAP, 32'h00000000);
		rdc(OFS_PERFCAP, 32'h0000003F);
	endtask : t_regs
	task automatic t_canon;
		wr(12'h100, 32'h00800000);
		chk(err, 1'b0);
		rdc(12'h100, 32'hFF800000);
		wr(12'h174, 32'h12345678);
		rdc(12'h174, 32'h00345678);
		wr(12'h108, 32'hFFFFFFFF);
		rdc(12'h108, 32'h8001FFFF);
		wr(OFS_LER_INFO, 32'h7FFE0000);
		chk(err, 1'b0);
		rdc(OFS_LER_INFO, 32'h00000000);
	endtask : t_canon
	task automatic t_trace;
		wr(OFS_CTRL, 32'h00000001);
		p.drive(4'h1, 1'b1, 1'b0, e1);
		#1;
		chk(trc_v, 1'b1);
		chk(trc_ent, e1);
		rdc(12'h104, e1.to_addr);
		p.drive(4'h1, 1'b1, 1'b1, e2);
		#1;
		chk(trc_v, 1'b0);
		rdc(12'h100, e1.from_addr);
		p.drive(4'h1, 1'b0, 1'b0, e2);
		#1;
		chk(trc_ent, e1);
	endtask : t_trace
	task automatic t_freeze;
		p.drive(4'h4, 1'b0, 1'b0, e1);
		repeat (2) @(posedge clk);
		#1;
		chk(rec_en, 1'b0);
		p.drive(4'h1, 1'b1, 1'b0, e2);
		#1;
		chk(trc_v, 1'b0);
		rdc(12'h100, e1.from_addr);
		rdc(OFS_GSTAT, 32'h00000001);
		wr(OFS_GSTAT, 32'h00000001);
		p.drive(4'h1, 1'b1, 1'b0, e2);
		#1;
		chk(trc_ent, e2);
		chk(rec_en, 1'b1);
	endtask : t_freeze
	task automatic t_sample;
		wr(OFS_DEPTH, 32'h00000009);
		rdc(OFS_DEPTH, 32'h00000008);
		wr(OFS_DEPTH, 32'h00000003);
		wr(OFS_SCFG, 32'h05000008);
		smp(5'h03, 32'h03000008);
		chk(first_ent, e2);
		wr(OFS_SCFG, 32'h02000008);
		smp(5'h02, 32'h02000008);
		wr(OFS_SCFG, 32'h05000000);
		smp(5'h00, 32'h00000000);
	endtask : t_sample
	task automatic t_idle;
		p.drive(4'h2, 1'b0, 1'b0, e2);
		rdc(OFS_LER_TO, e2.to_addr);
		pwr(5'b10000);
		rdc(12'h100, e2.from_addr);
		pwr(5'b11100);
		rdc(12'h100, e2.from_addr);
		pwr(5'b11000);
		rdc(12'h100, 32'h00000000);
		rdc(12'h108, 32'h00000000);
		rdc(OFS_CTRL, 32'h00000001);
		rdc(OFS_DEPTH, 32'h00000003);
		rdc(OFS_LER_TO, e2.to_addr);
	endtask : t_idle
	task automatic t_warm;
		p.drive(4'h1, 1'b1, 1'b0, e1);
		pwr(5'b00010);
		rdc(OFS_CTRL, 32'h00000000);
		rdc(12'h100, e1.from_addr);
		rdc(OFS_DEPTH, 32'h00000003);
		pwr(5'b00011);
		rdc(12'h100, 32'h00000000);
		rdc(OFS_DEPTH, 32'h00000008);
		rdc(OFS_LER_TO, 32'h00000000);
	endtask : t_warm
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_canon();
		t_trace();
		t_freeze();
		t_sample();
		t_idle();
		t_warm();
		give_verdict();
	end
endmodule : test_branch_record_state_retention
`default_nettype wire
